// file: hw/cfrs_core_function_rate_select.sv
// register bank selecting the sample-rate slot of each digital-core function
// assumes a single-cycle request strobe on sys_clk from the control interface
// Functional notes
// RULE1: the effects rate field sits in bits 15:11, codes 0x00 to 0x03 pick slots one to four, reset 0x00.
// RULE2: software writes only the four slot codes; other codes are reserved.
// RULE3: software picks only slots between 8 and 192 kHz for effects, tone, noise and drive rates.
// RULE4: software clears all filter, equaliser and compressor source selectors before changing the effects rate.
// RULE5: the tone generator rate sits in bits 15:11 at 0xb000 with the same encoding, reset zero.
// RULE6: the noise generator rate sits in a 5-bit field at 0xb400 with the same encoding, reset zero.
// RULE7: the first ultrasonic demodulator rate sits in a 5-bit field at 0xb804, reset zero.
// RULE8: the second ultrasonic demodulator rate sits in bits 31:27 at 0xb814, reset zero.
// RULE9: software sets each ultrasonic rate to the slot matching its 16 kHz output rate.
// RULE10: the pulse drive rate sits in bits 15:11 at 0xc000 with the same encoding, reset zero.
// RULE11: software clears all pulse drive source selectors before changing the drive rate.
// RULE12: software waits 125 us after clearing source selectors before writing the rate.
// RULE13: each rate field reads back what was last written and writes leave other bits alone.
`timescale 1ns/10ps
`default_nettype none
module cfrs_core_function_rate_select (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire cfrs_pkg::cfrs_req_type req,
    output cfrs_pkg::cfrs_rsp_type rsp,
    output cfrs_pkg::cfrs_rate_type [cfrs_pkg::CFRS_NUM_FUNC-1:0] funcRate,
    output logic [cfrs_pkg::CFRS_NUM_FUNC-1:0] reservedSeen
);
    import cfrs_pkg::*;

    logic [CFRS_NUM_FUNC-1:0] hit;
    logic [CFRS_NUM_FUNC-1:0] wrEn;
    logic [CFRS_CODE_W-1:0] fieldCode [CFRS_NUM_FUNC];
    logic [CFRS_DATA_W-1:0] readWord;
    logic anyHit;
    logic ack_q;
    logic addrError_q;
    logic [CFRS_DATA_W-1:0] rdata_q;
    logic [CFRS_NUM_FUNC-1:0] reservedSeen_q;
    logic [CFRS_NUM_FUNC-1:0] wrReserved;

    genvar g;
    generate
        for (g = 0; g < CFRS_NUM_FUNC; g++) begin : gFunc
            localparam int LSB = fieldLsb(g);
            cfrs_rate_type wrDecode;
            assign hit[g] = (req.addr == regOffset(g));
            assign wrEn[g] = req.write && hit[g];
            assign wrDecode = decodeRate(req.wdata[LSB +: CFRS_CODE_W]);
            assign wrReserved[g] = wrDecode.reserved; // RULE2
            // only the field bits are taken; other bits of the word are not this bank's
            cfrs_rate_field cfrs_rate_field_inst (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .wrEn(wrEn[g]),
                .wrCode(req.wdata[LSB +: CFRS_CODE_W]),
                .code(fieldCode[g]),
                .rate(funcRate[g])
            ); // RULE1 RULE5 RULE6 RULE7 RULE8 RULE10
        end
    endgenerate

    assign anyHit = |hit;

    // readback places each field at its own bit position, all else zero
    always_comb begin
        readWord = READ_ZERO;
        for (int i = 0; i < CFRS_NUM_FUNC; i++) begin
            if (hit[i]) begin
                readWord[fieldLsb(i) +: CFRS_CODE_W] = fieldCode[i]; // RULE13
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            addrError_q <= 1'b0;
        end else begin
            ack_q <= req.write || req.read;
            addrError_q <= (req.write || req.read) && !anyHit;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= READ_ZERO;
        end else if (req.read) begin
            rdata_q <= readWord; // RULE13
        end
    end

    // sticky note of a reserved code written; a new legal write clears it.
    // the bank still stores the code, it relies on software not doing this
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reservedSeen_q <= '0;
        end else begin
            for (int i = 0; i < CFRS_NUM_FUNC; i++) begin
                if (wrEn[i]) begin
                    reservedSeen_q[i] <= wrReserved[i]; // RULE2
                end
            end
        end
    end

    assign rsp.ack = ack_q;
    assign rsp.addrError = addrError_q;
    assign rsp.rdata = rdata_q;
    assign reservedSeen = reservedSeen_q;
endmodule // cfrs_core_function_rate_select
`default_nettype wire

// file: hw/cfrs_pkg.sv
// package for the core function rate select register bank
// assumes a 32-bit byte-addressed control port inside the device
package cfrs_pkg;

    localparam int CFRS_NUM_FUNC = 6;
    localparam int CFRS_ADDR_W = 32;
    localparam int CFRS_DATA_W = 32;
    localparam int CFRS_CODE_W = 5;
    localparam int CFRS_IDX_W = 3;

    // register byte addresses
    localparam logic [CFRS_ADDR_W-1:0] EFFECTS_RATE_CONFIG_OFS = 32'h0000a800;
    localparam logic [CFRS_ADDR_W-1:0] TONE_GEN_RATE_CONFIG_OFS = 32'h0000b000;
    localparam logic [CFRS_ADDR_W-1:0] NOISE_SOURCE_RATE_SELECT_CONFIG_OFS = 32'h0000b400;
    localparam logic [CFRS_ADDR_W-1:0] ULTRASONIC_ONE_RATE_CONFIG_OFS = 32'h0000b804;
    localparam logic [CFRS_ADDR_W-1:0] ULTRASONIC_TWO_RATE_CONFIG_OFS = 32'h0000b814;
    localparam logic [CFRS_ADDR_W-1:0] PULSE_DRIVE_RATE_CONFIG_OFS = 32'h0000c000;

    // least significant bit of each rate field
    localparam int FIELD_LSB_LOW = 11;
    localparam int FIELD_LSB_HIGH = 27;

    localparam logic [CFRS_CODE_W-1:0] RATE_CODE_RESET = 5'h00;
    localparam logic [CFRS_CODE_W-1:0] RATE_CODE_MAX = 5'h03;
    localparam logic [CFRS_DATA_W-1:0] READ_ZERO = 32'h00000000;

    // function index order of the bank
    typedef enum logic [CFRS_IDX_W-1:0] {
        FUNC_EFFECTS,
        FUNC_TONE,
        FUNC_NOISE,
        FUNC_ULTRA_ONE,
        FUNC_ULTRA_TWO,
        FUNC_PULSE_DRIVE
    } cfrs_func_type;

    // decoded rate selection handed to a function
    typedef struct packed {
        logic [1:0] slot;
        logic reserved;
    } cfrs_rate_type;

    // register port request
    typedef struct packed {
        logic write;
        logic read;
        logic [CFRS_ADDR_W-1:0] addr;
        logic [CFRS_DATA_W-1:0] wdata;
    } cfrs_req_type;

    // register port answer
    typedef struct packed {
        logic ack;
        logic addrError;
        logic [CFRS_DATA_W-1:0] rdata;
    } cfrs_rsp_type;

    function automatic logic [CFRS_ADDR_W-1:0] regOffset(input int idx);
        logic [CFRS_ADDR_W-1:0] ofs;
        ofs = EFFECTS_RATE_CONFIG_OFS;
        case (idx)
            1: ofs = TONE_GEN_RATE_CONFIG_OFS;
            2: ofs = NOISE_SOURCE_RATE_SELECT_CONFIG_OFS;
            3: ofs = ULTRASONIC_ONE_RATE_CONFIG_OFS;
            4: ofs = ULTRASONIC_TWO_RATE_CONFIG_OFS;
            5: ofs = PULSE_DRIVE_RATE_CONFIG_OFS;
            default: ofs = EFFECTS_RATE_CONFIG_OFS;
        endcase
        return ofs;
    endfunction

    function automatic int fieldLsb(input int idx);
        int lsb;
        lsb = FIELD_LSB_LOW;
        if ((idx == 3) || (idx == 4)) begin
            lsb = FIELD_LSB_HIGH;
        end
        return lsb;
    endfunction

    function automatic cfrs_rate_type decodeRate(input logic [CFRS_CODE_W-1:0] code);
        cfrs_rate_type r;
        r.slot = code[1:0];
        r.reserved = (code > RATE_CODE_MAX);
        return r;
    endfunction

endpackage

// file: hw/cfrs_rate_field.sv
// one 5-bit rate field with its decoded slot selection
// assumes write strobe and code come from logic on sys_clk
`timescale 1ns/10ps
`default_nettype none
module cfrs_rate_field (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wrEn,
    input wire logic [cfrs_pkg::CFRS_CODE_W-1:0] wrCode,
    output logic [cfrs_pkg::CFRS_CODE_W-1:0] code,
    output cfrs_pkg::cfrs_rate_type rate
);
    import cfrs_pkg::*;

    logic [CFRS_CODE_W-1:0] code_q;
    cfrs_rate_type rate_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            code_q <= RATE_CODE_RESET;
        end else if (wrEn) begin
            code_q <= wrCode;
        end
    end

    // decode registered so the function sees a glitch-free selection
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rate_q <= '0;
        end else if (wrEn) begin
            rate_q <= decodeRate(wrCode);
        end
    end

    assign code = code_q;
    assign rate = rate_q;
endmodule // cfrs_rate_field
`default_nettype wire

// file: sim/cfrs_core_function_rate_select_test.sv
// bench for the rate select bank
// drives the register port itself, no partner
`timescale 1ns/10ps
`default_nettype none
module cfrs_core_function_rate_select_test;
    import cfrs_pkg::*;
    logic sys_clk;
    logic nrst;
    cfrs_req_type req;
    cfrs_rsp_type rsp;
    cfrs_rate_type [CFRS_NUM_FUNC-1:0] funcRate;
    logic [CFRS_NUM_FUNC-1:0] reservedSeen;
    int failures = 0;
    int testsRun = 0;
    int cycles = 0;
    logic [31:0] ofs [6] = '{EFFECTS_RATE_CONFIG_OFS, TONE_GEN_RATE_CONFIG_OFS, NOISE_SOURCE_RATE_SELECT_CONFIG_OFS,
        ULTRASONIC_ONE_RATE_CONFIG_OFS, ULTRASONIC_TWO_RATE_CONFIG_OFS, PULSE_DRIVE_RATE_CONFIG_OFS};
    int lsb [6] = '{11, 11, 11, 27, 27, 11};
    cfrs_core_function_rate_select cfrs_core_function_rate_select_inst (.sys_clk(sys_clk), .nrst(nrst),
        .req(req), .rsp(rsp), .funcRate(funcRate), .reservedSeen(reservedSeen));
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ack lasts one cycle; the idle edge after it lets ack fall and keeps strobes from being set twice at once
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e,
        input logic err);
        req = '{w, !w, a, d};
        @(posedge sys_clk);
        #1;
        req.write = 1'h0;
        req.read = 1'h0;
        chk("ack", 32'h1, rsp.ack);
        chk("addrError", err, rsp.addrError);
        if (!w) begin
            chk("rdata", e, rsp.rdata);
        end
        @(posedge sys_clk);
        #1;
        chk("ackEnd", 32'h0, {rsp.ack, rsp.addrError});
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        req = '0;
        nrst = 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        nrst = 1'h1;
        chk("resetOut", 32'h0, {funcRate, reservedSeen});
        for (int i = 0; i < 6; i++) begin
            xfer(1'h0, ofs[i], 32'h0, 32'h0, 1'h0);
        end
        // neighbour bits written as ones must not show up on readback
        // source selectors live outside this bank and stay cleared all run, so rate writes are allowed
        for (int i = 0; i < 6; i++) begin
            for (int c = 0; c < 4; c++) begin
                xfer(1'h1, ofs[i], ~(32'h1f << lsb[i]) | (c << lsb[i]), 32'h0, 1'h0);
                chk("slot", c, funcRate[i].slot);
                chk("legal", 32'h0, {funcRate[i].reserved, reservedSeen[i]});
                xfer(1'h0, ofs[i], 32'h0, c << lsb[i], 1'h0);
            end
            xfer(1'h1, ofs[i], 32'h1f << lsb[i], 32'h0, 1'h0);
            chk("reserved", 32'h3, {funcRate[i].reserved, reservedSeen[i]});
        end
        xfer(1'h1, 32'h0000a804, '1, 32'h0, 1'h1);
        xfer(1'h0, 32'h0000a804, 32'h0, 32'h0, 1'h1);
        for (int i = 0; i < 6; i++) begin
            xfer(1'h0, ofs[i], 32'h0, 32'h1f << lsb[i], 1'h0);
        end
        // write then read on the very next edge sees the new code
        req = '{1'h1, 1'h0, TONE_GEN_RATE_CONFIG_OFS, 32'h00001000};
        @(posedge sys_clk);
        #1;
        req.write = 1'h0;
        req.read = 1'h1;
        @(posedge sys_clk);
        #1;
        req.read = 1'h0;
        chk("rdataNext", 32'h00001000, rsp.rdata);
        // reset in mid-run brings every field back to its reset code
        nrst = 1'h0;
        @(posedge sys_clk);
        #1;
        nrst = 1'h1;
        chk("resetAgain", 32'h0, {funcRate, reservedSeen});
        for (int i = 0; i < 6; i++) begin
            xfer(1'h0, ofs[i], 32'h0, 32'h0, 1'h0);
        end
        stop_test();
    end
endmodule // cfrs_core_function_rate_select_test
`default_nettype wire

// file: sim/cfrs_monitor.sv
// assertions on the rate select bank ports
// bound to the bank, single clock domain
`timescale 1ns/10ps
`default_nettype none
module cfrs_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire cfrs_pkg::cfrs_req_type req,
    input wire cfrs_pkg::cfrs_rsp_type rsp,
    input wire cfrs_pkg::cfrs_rate_type [cfrs_pkg::CFRS_NUM_FUNC-1:0] funcRate,
    input wire logic [cfrs_pkg::CFRS_NUM_FUNC-1:0] reservedSeen
);
    import cfrs_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // slot and reserved flag follow the written field one cycle later
    property fw(int i, logic [31:0] a, int l);
        req.write && req.addr == a |=> funcRate[i].slot == $past(req.wdata[l+:2])
            && funcRate[i].reserved == (|$past(req.wdata[l+2+:3]));
    endproperty
    a_ack_after_req: assert property ((req.write || req.read) |=> rsp.ack)
        else $error("no ack after request");
    a_field_holds: assert property (!req.write |=> $stable(funcRate))
        else $error("rate moved without write");
    a_no_spurious_ack: assert property ((!req.write && !req.read) |=> (!rsp.ack && !rsp.addrError))
        else $error("ack without request");
    a_effects_field: assert property (fw(0, EFFECTS_RATE_CONFIG_OFS, 11))
        else $error("effects rate wrong");
    a_tone_field: assert property (fw(1, TONE_GEN_RATE_CONFIG_OFS, 11))
        else $error("tone rate wrong");
    a_noise_field: assert property (fw(2, NOISE_SOURCE_RATE_SELECT_CONFIG_OFS, 11))
        else $error("noise rate wrong");
    a_ultra_one_field: assert property (fw(3, ULTRASONIC_ONE_RATE_CONFIG_OFS, 27))
        else $error("first ultrasonic rate wrong");
    a_ultra_two_field: assert property (fw(4, ULTRASONIC_TWO_RATE_CONFIG_OFS, 27))
        else $error("second ultrasonic rate wrong");
    a_drive_field: assert property (fw(5, PULSE_DRIVE_RATE_CONFIG_OFS, 11))
        else $error("drive rate wrong");
    cover property (rsp.addrError);
    cover property (req.write ##1 req.read);
    cover property (|reservedSeen);
endmodule // cfrs_monitor
bind cfrs_core_function_rate_select cfrs_monitor cfrs_monitor_inst (.sys_clk(sys_clk), .nrst(nrst), .req(req),
    .rsp(rsp), .funcRate(funcRate), .reservedSeen(reservedSeen));
`default_nettype wire
